/* hdl/seg_unit_defs.vh */
`ifndef SEG_UNIT_DEFS_VH
`define SEG_UNIT_DEFS_VH

// Selector fields
`define SEL_RPL_LSB 0
`define SEL_RPL_MSB 1
`define SEL_TABLE_BIT 2
`define SEL_INDEX_LSB 3
`define SEL_INDEX_MSB 15
`define SEL_INDEX_SHIFT 3

// Segment register numbers
`define SEG_CODE 3'h0
`define SEG_STACK 3'h1
`define SEG_DATA 3'h2
`define SEG_EXTRA1 3'h3
`define SEG_EXTRA2 3'h4
`define SEG_EXTRA3 3'h5
`define SEG_COUNT 6

// Descriptor fields, upper doubleword bit positions
`define DW1_BASE_MID_LSB 0
`define DW1_BASE_MID_MSB 7
`define DW1_TYPE_LSB 8
`define DW1_TYPE_MSB 11
`define DW1_EXPAND_DOWN_BIT 10
`define DW1_WRITE_BIT 9
`define DW1_CODE_BIT 11
`define DW1_KIND_BIT 12
`define DW1_DPL_LSB 13
`define DW1_DPL_MSB 14
`define DW1_PRESENT_BIT 15
`define DW1_LIMIT_HI_LSB 16
`define DW1_LIMIT_HI_MSB 19
`define DW1_UPPER_BOUND_BIT 22
`define DW1_GRAN_BIT 23
`define DW1_BASE_HI_LSB 24
`define DW1_BASE_HI_MSB 31

// Descriptor fields, lower doubleword
`define DW0_LIMIT_LO_LSB 0
`define DW0_LIMIT_LO_MSB 15
`define DW0_BASE_LO_LSB 16
`define DW0_BASE_LO_MSB 31

// Limit scaling and bounds
`define GRAN_SHIFT 12
`define GRAN_LOW_ONES 12'hFFF
`define BOUND_32 32'hFFFFFFFF
`define BOUND_16 32'h0000FFFF
`define DESC_HI_OFFSET 32'h00000004

// Access kinds
`define ACC_READ 2'h0
`define ACC_WRITE 2'h1
`define ACC_EXEC 2'h2

// Fault codes
`define FAULT_NONE 2'h0
`define FAULT_GP 2'h1
`define FAULT_NP 2'h2

`endif

/* hdl/seg_limit_check.v */
`timescale 1ns/1ps
`include "seg_unit_defs.vh"

module seg_limit_check (
   // Cached segment attributes
   input wire [19:0] raw_limit,
   input wire gran,
   input wire expand_down,
   input wire upper_bound,
   // Offset under test
   input wire [31:0] offset,
   // Result
   output wire in_range
);
   wire [31:0] eff_limit;
   wire [31:0] top;

   // Byte or 4-KByte units; low twelve bits ignored when scaled
   assign eff_limit = gran ? {raw_limit, `GRAN_LOW_ONES} : {12'h000, raw_limit}; // RULE11 RULE12 RULE21
   assign top = upper_bound ? `BOUND_32 : `BOUND_16; // RULE22
   assign in_range = expand_down ? ((offset > eff_limit) && (offset <= top)) : // RULE14
                     (offset <= eff_limit); // RULE13

endmodule // seg_limit_check

/* hdl/seg_unit.v */
`timescale 1ns/1ps
`include "seg_unit_defs.vh"

// Contract
// RULE1 - Selector bits 3..15 index 8192 entries; address is table base plus index times 8.
// RULE2 - Selector bit 2 picks global table when zero, local table when one.
// RULE3 - Selector bits 0..1 are the requested privilege level, 0 most privileged.
// RULE4 - Index zero, table bit zero is null; null load into data registers never faults.
// RULE5 - Memory access through a register holding null selector raises an exception.
// RULE6 - Null selector loaded into code or stack register raises general protection fault.
// RULE7 - Six segment registers; only loaded segments are accessible.
// RULE8 - Selector load fetches descriptor and caches base, limit, access in hidden part.
// RULE9 - Translation uses cached hidden part only; table changes need a reload.
// RULE10 - Loads come from explicit or implied transfers; visible selector is readable.
// RULE11 - Two limit fields concatenate to one 20-bit limit.
// RULE12 - Granularity clear counts bytes; set counts 4-KByte units.
// RULE13 - Expand-up accepts offsets up to the limit; beyond faults.
// RULE14 - Expand-down accepts offsets above limit up to the upper bound.
// RULE15 - Three base fields concatenate into one 32-bit linear base.
// RULE16 - Kind flag clear means system descriptor, set means code or data.
// RULE17 - Type field meaning depends on the kind flag; sets access and direction.
// RULE18 - Two-bit descriptor privilege level is kept and used for access control; the unit only reports it on xlat_dpl_r, with no privilege check.
// RULE19 - Loading a not-present descriptor raises a not-present fault.
// RULE20 - Software should align segment bases to 16 bytes; not enforced.
// RULE21 - Granular limit ignores twelve low offset bits; limit zero allows 0..4095.
// RULE22 - Expand-down upper bound is 4 GBytes with flag set, else 64 KBytes.
// RULE23 - Descriptor fields follow the customary two-doubleword layout.
module seg_unit (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Table base registers
   input wire [31:0] global_table_base_reg,
   input wire [31:0] local_table_base_reg,
   // Selector load request
   input wire load_req,
   input wire [2:0] load_seg,
   input wire [15:0] load_selector,
   input wire load_implied,
   output wire load_ready,
   output reg load_done_r,
   // Descriptor memory read port
   output reg mem_req_r,
   output reg [31:0] mem_addr_r,
   input wire mem_ack,
   input wire [31:0] mem_rdata,
   // Fault report
   output reg [1:0] fault_code_r,
   output reg [15:0] fault_selector_r,
   // Selector read-back
   input wire [2:0] read_seg,
   output reg [15:0] read_selector_r,
   // Address translation
   input wire xlat_req,
   input wire [2:0] xlat_seg,
   input wire [31:0] xlat_offset,
   input wire [1:0] xlat_kind,
   output reg xlat_valid_r,
   output reg [31:0] xlat_linear_r,
   output reg [1:0] xlat_fault_r,
   // Cached privilege of a segment
   output reg [1:0] xlat_dpl_r,
   output reg [1:0] xlat_rpl_r
);
   localparam ST_IDLE = 2'h0;
   localparam ST_LO = 2'h1;
   localparam ST_HI = 2'h2;

   // Visible and hidden parts
   reg [15:0] sel_r [0:`SEG_COUNT-1];
   reg [31:0] base_r [0:`SEG_COUNT-1];
   reg [19:0] limit_r [0:`SEG_COUNT-1];
   reg [3:0] type_r [0:`SEG_COUNT-1];
   reg kind_r [0:`SEG_COUNT-1];
   reg [1:0] dpl_r [0:`SEG_COUNT-1];
   reg gran_r [0:`SEG_COUNT-1];
   reg ub_r [0:`SEG_COUNT-1];
   reg null_r [0:`SEG_COUNT-1];

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [2:0] pend_seg_r;
   reg [15:0] pend_sel_r;
   reg [31:0] lo_word_r;

   wire sel_is_null;
   wire [31:0] table_base;
   wire [31:0] desc_addr;
   wire null_fault;
   wire [31:0] hi_w;
   wire hi_present;
   wire in_range;
   wire [1:0] kind_fault;
   wire seg_ok;
   integer i;

   ////////////////////////////////////////////////////////////////////////
   // Selector decode

   assign sel_is_null = (load_selector[`SEL_INDEX_MSB:`SEL_INDEX_LSB] == 13'h0) &&
                        !load_selector[`SEL_TABLE_BIT]; // RULE4
   assign table_base = load_selector[`SEL_TABLE_BIT] ? local_table_base_reg :
                       global_table_base_reg; // RULE2
   assign desc_addr = table_base + {16'h0000, load_selector[`SEL_INDEX_MSB:`SEL_INDEX_LSB],
                      3'h0}; // RULE1
   assign null_fault = sel_is_null &&
                       ((load_seg == `SEG_CODE) || (load_seg == `SEG_STACK)); // RULE6
   assign load_ready = (state_r == ST_IDLE);
   assign seg_ok = (load_seg < `SEG_COUNT); // RULE7

   assign hi_w = mem_rdata;
   assign hi_present = hi_w[`DW1_PRESENT_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Fetch sequencer

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (load_req && seg_ok && !sel_is_null) begin
               state_nxt = ST_LO; // RULE8
            end
         end
         ST_LO: begin
            if (mem_ack) begin
               state_nxt = ST_HI;
            end
         end
         ST_HI: begin
            if (mem_ack) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         pend_seg_r <= 3'h0;
         pend_sel_r <= 16'h0000;
         lo_word_r <= 32'h00000000;
         mem_req_r <= 1'b0;
         mem_addr_r <= 32'h00000000;
         load_done_r <= 1'b0;
         fault_code_r <= `FAULT_NONE;
         fault_selector_r <= 16'h0000;
         for (i = 0; i < `SEG_COUNT; i = i + 1) begin
            sel_r[i] <= 16'h0000;
            base_r[i] <= 32'h00000000;
            limit_r[i] <= 20'h00000;
            type_r[i] <= 4'h0;
            kind_r[i] <= 1'b0;
            dpl_r[i] <= 2'h0;
            gran_r[i] <= 1'b0;
            ub_r[i] <= 1'b0;
            null_r[i] <= 1'b1;
         end
      end else begin
         state_r <= state_nxt;
         load_done_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               // Explicit and implied loads share this path
               if (load_req && seg_ok) begin // RULE10
                  pend_seg_r <= load_seg;
                  pend_sel_r <= load_selector;
                  if (null_fault) begin
                     load_done_r <= 1'b1;
                     fault_code_r <= `FAULT_GP; // RULE6
                     fault_selector_r <= load_selector;
                  end else if (sel_is_null) begin
                     load_done_r <= 1'b1;
                     fault_code_r <= `FAULT_NONE; // RULE4
                     fault_selector_r <= load_selector;
                     sel_r[load_seg] <= load_selector;
                     null_r[load_seg] <= 1'b1;
                  end else begin
                     mem_req_r <= 1'b1;
                     mem_addr_r <= desc_addr; // RULE1
                  end
               end
            end
            ST_LO: begin
               if (mem_ack) begin
                  lo_word_r <= mem_rdata;
                  mem_addr_r <= mem_addr_r + `DESC_HI_OFFSET;
               end
            end
            ST_HI: begin
               if (mem_ack) begin
                  mem_req_r <= 1'b0;
                  load_done_r <= 1'b1;
                  fault_selector_r <= pend_sel_r;
                  if (!hi_present) begin
                     fault_code_r <= `FAULT_NP; // RULE19
                  end else begin
                     fault_code_r <= `FAULT_NONE;
                     sel_r[pend_seg_r] <= pend_sel_r; // RULE8
                     null_r[pend_seg_r] <= 1'b0;
                     base_r[pend_seg_r] <= {hi_w[`DW1_BASE_HI_MSB:`DW1_BASE_HI_LSB],
                        hi_w[`DW1_BASE_MID_MSB:`DW1_BASE_MID_LSB],
                        lo_word_r[`DW0_BASE_LO_MSB:`DW0_BASE_LO_LSB]}; // RULE15 RULE23
                     limit_r[pend_seg_r] <= {hi_w[`DW1_LIMIT_HI_MSB:`DW1_LIMIT_HI_LSB],
                        lo_word_r[`DW0_LIMIT_LO_MSB:`DW0_LIMIT_LO_LSB]}; // RULE11 RULE23
                     type_r[pend_seg_r] <= hi_w[`DW1_TYPE_MSB:`DW1_TYPE_LSB]; // RULE17
                     kind_r[pend_seg_r] <= hi_w[`DW1_KIND_BIT]; // RULE16
                     dpl_r[pend_seg_r] <= hi_w[`DW1_DPL_MSB:`DW1_DPL_LSB]; // RULE18
                     gran_r[pend_seg_r] <= hi_w[`DW1_GRAN_BIT]; // RULE12
                     ub_r[pend_seg_r] <= hi_w[`DW1_UPPER_BOUND_BIT]; // RULE22
                  end
               end
            end
            default: begin
               mem_req_r <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Translation from cached hidden part only

   seg_limit_check u_limit (
      .raw_limit(limit_r[xlat_seg]),
      .gran(gran_r[xlat_seg]), // RULE21
      .expand_down(kind_r[xlat_seg] && !type_r[xlat_seg][3] && type_r[xlat_seg][2]),
      .upper_bound(ub_r[xlat_seg]),
      .offset(xlat_offset),
      .in_range(in_range)
   );

   // Data writes need write-enable; code is never writable, reads need read-enable
   assign kind_fault =
      !kind_r[xlat_seg] ? `FAULT_GP : // RULE16
      (type_r[xlat_seg][3] ?
         ((xlat_kind == `ACC_WRITE) ||
          ((xlat_kind == `ACC_READ) && !type_r[xlat_seg][1]) ? `FAULT_GP : `FAULT_NONE) :
         ((xlat_kind == `ACC_EXEC) ||
          ((xlat_kind == `ACC_WRITE) && !type_r[xlat_seg][1]) ? `FAULT_GP : `FAULT_NONE));
   // RULE17

   always @(posedge core_clk) begin
      if (!rst_n) begin
         xlat_valid_r <= 1'b0;
         xlat_linear_r <= 32'h00000000;
         xlat_fault_r <= `FAULT_NONE;
         xlat_dpl_r <= 2'h0;
         xlat_rpl_r <= 2'h0;
         read_selector_r <= 16'h0000;
      end else begin
         read_selector_r <= (read_seg < `SEG_COUNT) ? sel_r[read_seg] : 16'h0000; // RULE10
         xlat_valid_r <= xlat_req;
         xlat_linear_r <= 32'h00000000;
         xlat_fault_r <= `FAULT_NONE;
         if (xlat_req) begin
            if (!(xlat_seg < `SEG_COUNT) || null_r[xlat_seg]) begin
               xlat_fault_r <= `FAULT_GP; // RULE5 RULE7
            end else if (!in_range) begin
               xlat_fault_r <= `FAULT_GP; // RULE13 RULE14
            end else if (kind_fault != `FAULT_NONE) begin
               xlat_fault_r <= kind_fault;
            end else begin
               xlat_linear_r <= base_r[xlat_seg] + xlat_offset; // RULE9
            end
            xlat_dpl_r <= dpl_r[xlat_seg]; // RULE18
            xlat_rpl_r <= sel_r[xlat_seg][`SEL_RPL_MSB:`SEL_RPL_LSB]; // RULE3
         end
      end
   end

endmodule // seg_unit

/* tb/seg_unit_properties.sv */
`timescale 1ns/1ps
module seg_unit_properties (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Load side
   input wire [31:0] global_table_base_reg,
   input wire [31:0] local_table_base_reg,
   input wire load_req,
   input wire [2:0] load_seg,
   input wire [15:0] load_selector,
   input wire load_ready,
   input wire load_done_r,
   input wire [1:0] fault_code_r,
   // Memory side
   input wire mem_req_r,
   input wire [31:0] mem_addr_r,
   input wire mem_ack,
   // Translation
   input wire xlat_req,
   input wire [2:0] xlat_seg,
   input wire xlat_valid_r,
   input wire [31:0] xlat_linear_r,
   input wire [1:0] xlat_fault_r
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   reg hi_r;
   reg [15:0] sel_r;
   wire take = load_req && load_ready && load_seg < 3'h6;
   wire nul = load_selector[15:2] == 14'h0;
   // Second descriptor word pending
   always @(posedge core_clk) begin
      sel_r <= load_selector;
      if (!rst_n)
         hi_r <= 1'b0;
      else if (mem_req_r && mem_ack)
         hi_r <= !hi_r;
   end
   sequence lo_word;
      mem_req_r && mem_ack && !hi_r;
   endsequence
   sequence hi_word;
      mem_req_r && mem_ack && hi_r;
   endsequence
   AST_NULL_CODE:
   assert property (take && nul && load_seg < 3'h2 |=> load_done_r && fault_code_r == 2'h1)
      else $error("null code or stack load not refused");
   AST_NULL_DATA:
   assert property (take && nul && load_seg > 3'h1 |=> load_done_r && fault_code_r == 2'h0)
      else $error("null data load faulted");
   AST_DESC_ADDR:
   assert property (take && !nul |=> mem_req_r && mem_addr_r == (sel_r[2] ?
      local_table_base_reg : global_table_base_reg) + {16'h0, sel_r[15:3], 3'h0})
      else $error("descriptor address wrong");
   AST_HI_ADDR:
   assert property (lo_word |=> mem_req_r && mem_addr_r == $past(mem_addr_r) + 32'h4)
      else $error("upper word address wrong");
   AST_LOAD_END:
   assert property (hi_word |=> !mem_req_r && load_done_r)
      else $error("load did not finish");
   AST_DONE_PULSE:
   assert property (load_done_r && !take |=> !load_done_r)
      else $error("done longer than one cycle");
   AST_XLAT_ANSWER:
   assert property (xlat_req |=> xlat_valid_r)
      else $error("translation not answered");
   AST_BAD_SEG:
   assert property (xlat_req && xlat_seg > 3'h5 |=> xlat_fault_r == 2'h1)
      else $error("bad register not refused");
   AST_FAULT_LIN:
   assert property (xlat_valid_r && xlat_fault_r != 2'h0 |-> xlat_linear_r == 32'h0)
      else $error("faulted translation gave address");
endmodule // seg_unit_properties

bind seg_unit seg_unit_properties i_seg_unit_properties (.*);

/* tb/desc_mem_model.sv */
`timescale 1ns/1ps
module desc_mem_model (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Descriptor read port
   input wire mem_req_r,
   input wire [31:0] mem_addr_r,
   output reg mem_ack,
   output reg [31:0] mem_rdata,
   // Answer delay in cycles
   input wire [1:0] wait_cycles
);
   reg [31:0] words [0:255];
   reg [1:0] cnt_r;
   // Data toggles when not answering
   always @(posedge core_clk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!rst_n || !mem_req_r || mem_ack) begin
         cnt_r <= 2'h0;
         if (!rst_n)
            mem_rdata <= 32'h0;
      end else if (cnt_r == wait_cycles) begin
         mem_ack <= 1'b1;
         mem_rdata <= words[mem_addr_r[9:2]];
      end else
         cnt_r <= cnt_r + 2'h1;
   end
endmodule // desc_mem_model

/* tb/seg_unit_tb_top.sv */
`timescale 1ns/1ps
module seg_unit_tb_top;
   reg core_clk = 1'b0;
   reg rst_n = 1'b0;
   reg load_req = 1'b0;
   reg [2:0] load_seg = 3'h0;
   reg [15:0] load_selector = 16'h0;
   reg load_implied = 1'b0;
   reg [2:0] read_seg = 3'h0;
   reg xlat_req = 1'b0;
   reg [2:0] xlat_seg = 3'h0;
   reg [31:0] xlat_offset = 32'h0;
   reg [1:0] xlat_kind = 2'h0;
   reg [1:0] wait_cycles = 2'h0;
   wire load_ready, load_done_r, mem_req_r, mem_ack, xlat_valid_r;
   wire [31:0] mem_addr_r, mem_rdata, xlat_linear_r;
   wire [1:0] fault_code_r, xlat_fault_r, xlat_dpl_r, xlat_rpl_r;
   wire [15:0] fault_selector_r, read_selector_r;
   integer bad_count = 0;
   integer compares = 0;
   integer i;
   integer j;
   always #2.5 core_clk = ~core_clk;
   seg_unit i_seg_unit (.global_table_base_reg(32'h00000100),
      .local_table_base_reg(32'h00000200), .*);
   desc_mem_model i_desc_mem_model (.*);
   ////////////////////////////////////////
   task stop_test;
      begin
         if (bad_count == 0 && compares > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task put(input [31:0] a, input [31:0] bs, input [19:0] lm, input [3:0] ty,
      input [1:0] dp, input p, input [1:0] bg);
      begin
         i_desc_mem_model.words[a[9:2]] = {bs[15:0], lm[15:0]};
         i_desc_mem_model.words[a[9:2] + 8'h1] =
            {bs[31:24], bg, 2'h0, lm[19:16], p, dp, 1'b1, ty, bs[23:16]};
      end
   endtask
   task load(input [2:0] s, input [15:0] sel, input [1:0] code);
      begin
         load_seg = s;
         load_selector = sel;
         load_implied = ~load_implied;
         load_req = 1'b1;
         @(negedge core_clk);
         load_req = 1'b0;
         i = 0;
         while (load_done_r !== 1'b1 && i < 40) begin
            @(negedge core_clk);
            i = i + 1;
         end
         if (i == 40) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t load timed out", $time);
            stop_test;
         end
         chk(fault_code_r, code);
         chk(fault_selector_r, sel);
         // Gap so the next request starts on a fresh edge
         @(negedge core_clk);
      end
   endtask
   // A zero address means a fault is expected
   task xl(input [2:0] s, input [31:0] off, input [1:0] k, input [31:0] lin);
      begin
         xlat_req = 1'b1;
         xlat_seg = s;
         xlat_offset = off;
         xlat_kind = k;
         @(negedge core_clk);
         chk(xlat_valid_r, 32'h1);
         chk(xlat_linear_r, lin);
         chk(xlat_fault_r, lin === 32'h0);
      end
   endtask
   task rb(input [2:0] s, input [15:0] sel);
      begin
         read_seg = s;
         @(negedge core_clk);
         chk(read_selector_r, sel);
      end
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (8) @(negedge core_clk);
      rst_n = 1'b1;
      @(negedge core_clk);
      for (j = 0; j < 6; j = j + 1) rb(j[2:0], 16'h0);
      xl(3'h2, 32'h0, 2'h0, 32'h0);
      xl(3'h6, 32'h0, 2'h0, 32'h0);
      for (j = 0; j < 6; j = j + 1) load(j[2:0], 16'h0003, j < 2);
      put(32'h108, 32'h00010000, 20'h00FFF, 4'hA, 2'h0, 1'b1, 2'h0);
      put(32'h110, 32'h12345670, 20'h0, 4'h2, 2'h0, 1'b1, 2'h2);
      put(32'h118, 32'h00200000, 20'h00FFF, 4'h6, 2'h1, 1'b1, 2'h0);
      put(32'h120, 32'h0, 20'h0, 4'h2, 2'h0, 1'b0, 2'h0);
      put(32'h228, 32'h00ABCDE0, 20'h000FF, 4'h0, 2'h3, 1'b1, 2'h0);
      put(32'h100F8, 32'h00000010, 20'h00010, 4'h6, 2'h0, 1'b1, 2'h1);
      wait_cycles = 2'h2;
      load(3'h0, 16'h0008, 2'h0);
      rb(3'h0, 16'h0008);
      xl(3'h0, 32'h0FFF, 2'h2, 32'h00010FFF);
      xl(3'h0, 32'h1000, 2'h2, 32'h0);
      xl(3'h0, 32'h10, 2'h1, 32'h0);
      wait_cycles = 2'h0;
      load(3'h2, 16'h0010, 2'h0);
      xl(3'h2, 32'h0FFF, 2'h0, 32'h1234666F);
      xl(3'h2, 32'h1000, 2'h1, 32'h0);
      load(3'h3, 16'h0019, 2'h0);
      xl(3'h3, 32'h1000, 2'h1, 32'h00201000);
      xl(3'h3, 32'h0FFF, 2'h0, 32'h0);
      xl(3'h3, 32'hFFFF, 2'h0, 32'h0020FFFF);
      xl(3'h3, 32'h10000, 2'h0, 32'h0);
      load(3'h4, 16'h002F, 2'h0);
      xl(3'h4, 32'h10, 2'h0, 32'h00ABCDF0);
      chk(xlat_dpl_r, 32'h3);
      chk(xlat_rpl_r, 32'h3);
      xl(3'h4, 32'h10, 2'h1, 32'h0);
      load(3'h5, 16'hFFF8, 2'h0);
      xl(3'h5, 32'hFFFFFFFF, 2'h1, 32'h0000000F);
      xl(3'h5, 32'h10, 2'h1, 32'h0);
      load(3'h1, 16'h0020, 2'h2);
      rb(3'h1, 16'h0);
      put(32'h110, 32'h40000000, 20'h0, 4'h2, 2'h0, 1'b1, 2'h2);
      xl(3'h2, 32'h4, 2'h0, 32'h12345674);
      load(3'h2, 16'h0010, 2'h0);
      xl(3'h2, 32'h4, 2'h0, 32'h40000004);
      xl(3'h2, 32'h4, 2'h2, 32'h0);
      put(32'h120, 32'h0, 20'h000FF, 4'h2, 2'h0, 1'b1, 2'h0);
      i_desc_mem_model.words[8'h49][12] = 1'b0;
      load(3'h4, 16'h0020, 2'h0);
      xl(3'h4, 32'h10, 2'h0, 32'h0);
      stop_test;
   end
endmodule // seg_unit_tb_top
